// ==== core/ddrsp_buf2.sv ====
// two-entry valid/ready buffer holding read bursts
`timescale 1ns/100ps
module ddrsp_buf2 #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 2
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] slot_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  // honest full and empty straight from the occupancy count
  assign o_in_ready = (count_reg != (PW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = slot_reg[rd_ptr_reg];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  // storage, written only on an accepted push
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      slot_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  // pointers wrap at depth, not at a power of two
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ==== core/ddrsp_map.svh ====
// timing counts and field positions for the ddr sram two-word burst port
`ifndef DDRSP_MAP_SVH
`define DDRSP_MAP_SVH

// core clock rate in MHz (8 ns period)
`define DDRSP_CORE_MHZ 125
// output impedance recalibration interval, microseconds
`define DDRSP_ZQ_PERIOD_US 20
// interval in core cycles: period in microseconds times clock rate in MHz
`define DDRSP_ZQ_CYCLES (`DDRSP_ZQ_PERIOD_US * `DDRSP_CORE_MHZ)
// width of the recalibration counter
`define DDRSP_ZQ_CNT_W 12
// bits per byte lane of the data bus
`define DDRSP_LANE_BITS 9
// words per burst
`define DDRSP_BURST_WORDS 2
// position of the first word inside a buffered burst entry
`define DDRSP_WORD0_LSB 0

`endif

// ==== core/ddrsp_pkg.sv ====
// types shared by the ddr sram two-word burst port
package ddrsp_pkg;

  // read launch sequencer states
  typedef enum logic [1:0] {
    DDRSP_RD_IDLE,
    DDRSP_RD_WAIT_COMP,
    DDRSP_RD_WAIT_TRUE
  } ddrsp_rd_state_t;

endpackage

// ==== core/ddrsp_port.sv ====
// device-side logic of a ddr sram port with two-word bursts
`timescale 1ns/100ps
`include "ddrsp_map.svh"

module ddrsp_port #(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 4,
  parameter int LANES = DATA_W / `DDRSP_LANE_BITS
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_k,
  input wire logic i_k_n,
  input wire logic i_c,
  input wire logic i_c_n,
  input wire logic i_load_strobe_n,
  input wire logic i_rd_wr_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_burst_start_word_select,
  input wire logic [LANES-1:0] i_byte_lane_write_select_n,
  input wire logic [DATA_W-1:0] i_shared_data_bus_in,
  output logic [DATA_W-1:0] o_shared_data_bus_out,
  output logic o_shared_data_bus_oe,
  output logic o_echo_clock_pair_p,
  output logic o_echo_clock_pair_n,
  input wire logic i_pll_bypass_n,
  output logic o_pll_bypassed,
  output logic o_single_clock_mode,
  output logic o_impedance_update
);
  import ddrsp_pkg::*;

  localparam int PIN_W = 3 + ADDR_W + LANES + DATA_W;
  localparam int MEM_D = 2 ** (ADDR_W + 1);
  localparam int BW = `DDRSP_BURST_WORDS * DATA_W;
  localparam logic [`DDRSP_ZQ_CNT_W-1:0] ZQ_LAST = `DDRSP_ZQ_CNT_W'(`DDRSP_ZQ_CYCLES - 1);

  // word index inside the array: linear burst order by flipping the low bit
  function automatic logic [ADDR_W:0] word_idx(input logic [ADDR_W-1:0] a,
                                               input logic start, input logic beat);
    word_idx = {a, start ^ beat};
  endfunction

  // synchronisers: clocks get a third stage for edge finding
  logic [3:0] clk_s1_reg;
  logic [3:0] clk_s2_reg;
  logic [3:0] clk_s3_reg;
  logic [PIN_W-1:0] pin_s1_reg;
  logic [PIN_W-1:0] pin_s2_reg;
  logic bypass_s1_reg;
  logic bypass_s2_reg;

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      clk_s1_reg <= 4'h0;
      clk_s2_reg <= 4'h0;
      clk_s3_reg <= 4'h0;
    end else begin
      clk_s1_reg <= {i_c_n, i_c, i_k_n, i_k};
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
    end
  end

  // controls and data ride the same two stages as the clocks
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      pin_s1_reg <= '1;
      pin_s2_reg <= '1;
      bypass_s1_reg <= 1'b1;
      bypass_s2_reg <= 1'b1;
    end else begin
      pin_s1_reg <= {i_load_strobe_n, i_rd_wr_n, i_burst_start_word_select, i_addr,
                     i_byte_lane_write_select_n, i_shared_data_bus_in};
      pin_s2_reg <= pin_s1_reg;
      bypass_s1_reg <= i_pll_bypass_n;
      bypass_s2_reg <= bypass_s1_reg;
    end
  end

  logic ld_n;
  logic rd_sel;
  logic a0;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0] bw_n;
  logic [DATA_W-1:0] din;
  assign {ld_n, rd_sel, a0, addr, bw_n, din} = pin_s2_reg;

  logic k_rise;
  logic kn_rise;
  logic c_rise;
  logic cn_rise;
  logic single_clk;
  logic ref_true_rise;
  logic ref_comp_rise;
  logic start_sel;
  assign k_rise = clk_s2_reg[0] & ~clk_s3_reg[0];
  assign kn_rise = clk_s2_reg[1] & ~clk_s3_reg[1];
  assign c_rise = clk_s2_reg[2] & ~clk_s3_reg[2];
  assign cn_rise = clk_s2_reg[3] & ~clk_s3_reg[3];
  assign single_clk = clk_s2_reg[2] & clk_s2_reg[3];
  assign ref_true_rise = single_clk ? k_rise : c_rise;
  assign ref_comp_rise = single_clk ? kn_rise : cn_rise;
  assign start_sel = (DATA_W > `DDRSP_LANE_BITS) ? a0 : 1'b0;

  logic load_rd;
  logic load_wr;
  assign load_rd = k_rise & ~ld_n & rd_sel;
  assign load_wr = k_rise & ~ld_n & ~rd_sel;

  logic [DATA_W-1:0] mem [MEM_D];

  // write pipeline: pending from the load edge, active after first word
  logic wr_pend_reg;
  logic wr_act_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic wr_start_reg;
  logic [ADDR_W-1:0] wr_act_addr_reg;
  logic wr_act_start_reg;

  // write sequencing, first word one input cycle after load
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      wr_pend_reg <= 1'b0;
      wr_act_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_start_reg <= 1'b0;
      wr_act_addr_reg <= '0;
      wr_act_start_reg <= 1'b0;
    end else if (k_rise) begin
      wr_pend_reg <= load_wr;
      wr_addr_reg <= addr;
      wr_start_reg <= start_sel;
      wr_act_reg <= wr_pend_reg;
      wr_act_addr_reg <= wr_addr_reg;
      wr_act_start_reg <= wr_start_reg;
    end else if (kn_rise) begin
      wr_act_reg <= 1'b0;
    end
  end

  // words caught at true then complementary input rise
  always_ff @(posedge i_core_clk) begin
    for (int l = 0; l < LANES; l++) begin
      // lane written only when its select is low
      if (k_rise && wr_pend_reg && !bw_n[l]) begin
        mem[word_idx(wr_addr_reg, wr_start_reg, 1'b0)][l*`DDRSP_LANE_BITS +: `DDRSP_LANE_BITS]
          <= din[l*`DDRSP_LANE_BITS +: `DDRSP_LANE_BITS];
      end else if (kn_rise && wr_act_reg && !bw_n[l]) begin
        mem[word_idx(wr_act_addr_reg, wr_act_start_reg, 1'b1)][l*`DDRSP_LANE_BITS +: `DDRSP_LANE_BITS]
          <= din[l*`DDRSP_LANE_BITS +: `DDRSP_LANE_BITS];
      end
    end
  end

  // read fetch: a whole burst is one buffer entry, held here while full
  logic fetch_valid_reg;
  logic [BW-1:0] fetch_data_reg;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_pop;
  logic [BW-1:0] buf_out_data;

  // linear order: word0 at start, word1 at flipped low bit
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      fetch_valid_reg <= 1'b0;
      fetch_data_reg <= '0;
    end else if (load_rd) begin
      fetch_valid_reg <= 1'b1;
      fetch_data_reg <= {mem[word_idx(addr, start_sel, 1'b1)],
                         mem[word_idx(addr, start_sel, 1'b0)]};
    end else if (buf_in_ready) begin
      fetch_valid_reg <= 1'b0;
    end
  end

  ddrsp_buf2 #(
    .WIDTH(BW),
    .DEPTH(2)
  ) u_rd_buf (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_in_valid(fetch_valid_reg),
    .o_in_ready(buf_in_ready),
    .i_in_data(fetch_data_reg),
    .o_out_valid(buf_out_valid),
    .i_out_ready(buf_pop),
    .o_out_data(buf_out_data)
  );

  // reads loaded but not yet started on the output side
  ddrsp_rd_state_t rd_state_reg;
  logic [1:0] owed_reg;
  logic start_burst;
  logic launch0;
  logic launch1;
  assign start_burst = ref_true_rise && (owed_reg != 2'h0) &&
                       (rd_state_reg == DDRSP_RD_IDLE || rd_state_reg == DDRSP_RD_WAIT_TRUE);
  assign launch0 = ref_comp_rise && rd_state_reg == DDRSP_RD_WAIT_COMP && buf_out_valid;
  assign launch1 = ref_true_rise && rd_state_reg == DDRSP_RD_WAIT_TRUE;
  // the entry leaves once its second word is on the bus
  assign buf_pop = launch1 & buf_out_valid;

  // owed count; a load and a start in one cycle cancel out
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      owed_reg <= 2'h0;
    end else if (load_rd && !start_burst) begin
      owed_reg <= owed_reg + 2'h1;
    end else if (start_burst && !load_rd) begin
      owed_reg <= owed_reg - 2'h1;
    end
  end

  // first word at C#(t+1), second at C(t+2)
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      rd_state_reg <= DDRSP_RD_IDLE;
    end else begin
      unique case (rd_state_reg)
        DDRSP_RD_IDLE: begin
          if (start_burst) begin
            rd_state_reg <= DDRSP_RD_WAIT_COMP;
          end
        end
        DDRSP_RD_WAIT_COMP: begin
          if (ref_comp_rise) begin
            rd_state_reg <= DDRSP_RD_WAIT_TRUE;
          end
        end
        DDRSP_RD_WAIT_TRUE: begin
          // back-to-back bursts chain without a gap
          if (ref_true_rise) begin
            rd_state_reg <= start_burst ? DDRSP_RD_WAIT_COMP : DDRSP_RD_IDLE;
          end
        end
      endcase
    end
  end

  // bus drive: window opens at word0, closes half a period after word1
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_shared_data_bus_out <= '0;
      o_shared_data_bus_oe <= 1'b0;
    end else if (launch0) begin
      o_shared_data_bus_out <= buf_out_data[`DDRSP_WORD0_LSB +: DATA_W];
      o_shared_data_bus_oe <= 1'b1;
    end else if (launch1) begin
      o_shared_data_bus_out <= buf_out_data[DATA_W +: DATA_W];
    end else if (ref_comp_rise) begin
      // idle cycle leaves the bus floating
      o_shared_data_bus_oe <= 1'b0;
    end
  end

  // echo clocks follow the reference regardless of bus state
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_echo_clock_pair_p <= 1'b0;
      o_echo_clock_pair_n <= 1'b0;
    end else begin
      o_echo_clock_pair_p <= single_clk ? clk_s2_reg[0] : clk_s2_reg[2];
      o_echo_clock_pair_n <= single_clk ? clk_s2_reg[1] : clk_s2_reg[3];
    end
  end

  // status levels; bypass only changes reporting, no pll is modelled
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_pll_bypassed <= 1'b0;
      o_single_clock_mode <= 1'b0;
    end else begin
      // bypass pin low marks debug clocking
      o_pll_bypassed <= ~bypass_s2_reg;
      o_single_clock_mode <= single_clk;
    end
  end

  logic [`DDRSP_ZQ_CNT_W-1:0] zq_cnt_reg;
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      zq_cnt_reg <= '0;
      o_impedance_update <= 1'b0;
    end else if (zq_cnt_reg == ZQ_LAST) begin
      zq_cnt_reg <= '0;
      o_impedance_update <= 1'b1;
    end else begin
      zq_cnt_reg <= zq_cnt_reg + 1'b1;
      o_impedance_update <= 1'b0;
    end
  end
endmodule

// ==== verif/ddrsp_ctrl_model.sv ====
// behavioural memory controller driving the port's pins
`timescale 1ns/100ps
module ddrsp_ctrl_model (
  input wire logic i_run,
  input wire logic i_single,
  output logic o_k,
  output logic o_k_n,
  output logic o_c,
  output logic o_c_n,
  output logic o_load_strobe_n,
  output logic o_rd_wr_n,
  output logic [3:0] o_addr,
  output logic o_start,
  output logic [1:0] o_lane_n,
  output logic [17:0] o_data
);
  // link clock, phase unrelated to the core clock; parks low while stopped
  initial begin
    o_k = 1'b0;
    #13.7;
    forever begin
      #40;
      o_k = i_run ? ~o_k : 1'b0;
    end
  end
  assign o_k_n = i_run ? ~o_k : 1'b0;
  // output clocks static high when unused
  assign o_c = i_single | o_k;
  assign o_c_n = i_single | o_k_n;
  initial begin
    o_load_strobe_n = 1'b1;
    o_rd_wr_n = 1'b1;
    o_addr = 4'h0;
    o_start = 1'b0;
    o_lane_n = 2'b11;
    o_data = 18'h00000;
  end
  // one load; for writes the two words follow
  task automatic burst(input logic ld_n, input logic rd, input logic [3:0] a, input logic s,
      input logic [17:0] w0, input logic [17:0] w1, input logic [1:0] b0, input logic [1:0] b1);
    @(negedge o_k);
    o_load_strobe_n = ld_n;
    o_rd_wr_n = rd;
    o_addr = a;
    o_start = s;
    @(posedge o_k);
    #20;
    o_load_strobe_n = 1'b1;
    o_rd_wr_n = ~rd;
    o_addr = ~a;
    o_start = ~s;
    if (!rd) begin
      @(negedge o_k);
      // words and lane selects per input clock rise
      o_data = w0;
      o_lane_n = b0;
      @(posedge o_k);
      #20;
      o_data = w1;
      o_lane_n = b1;
      @(negedge o_k);
      #20;
      o_data = ~w1;
      o_lane_n = 2'b11;
    end
  endtask
endmodule

// ==== verif/ddrsp_port_checker.sv ====
// port assertions for the ddr sram two-word burst port
`timescale 1ns/100ps
module ddrsp_port_checker (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_k,
  input wire logic i_c,
  input wire logic i_c_n,
  input wire logic i_load_strobe_n,
  input wire logic i_rd_wr_n,
  input wire logic i_pll_bypass_n,
  input wire logic o_shared_data_bus_oe,
  input wire logic o_echo_clock_pair_p,
  input wire logic o_single_clock_mode,
  input wire logic o_pll_bypassed,
  input wire logic o_impedance_update
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  logic k_reg;
  logic [5:0] rd_age_reg;
  logic [24:0] rd_hist_reg;
  logic [11:0] zq_cnt_reg;
  logic zq_seen_reg;
  // raw true clock, one cycle back
  always_ff @(posedge i_core_clk) begin
    k_reg <= i_k;
  end
  // age of the last read load at the pins; saturates so idle time stays visible
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      rd_age_reg <= 6'h3f;
    end else if (i_k && !k_reg && !i_load_strobe_n && i_rd_wr_n) begin
      rd_age_reg <= 6'h00;
    end else if (rd_age_reg != 6'h3f) begin
      rd_age_reg <= rd_age_reg + 6'h01;
    end
  end
  // read loads at the pins, bit n set n+1 cycles back; chained reads keep older loads visible
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      rd_hist_reg <= 25'h0000000;
    end else begin
      rd_hist_reg <= {rd_hist_reg[23:0], i_k && !k_reg && !i_load_strobe_n && i_rd_wr_n};
    end
  end
  // cycles since the last impedance update
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      zq_cnt_reg <= 12'h000;
      zq_seen_reg <= 1'b0;
    end else begin
      zq_cnt_reg <= o_impedance_update ? 12'h001 : zq_cnt_reg + 12'h001;
      zq_seen_reg <= zq_seen_reg | o_impedance_update;
    end
  end
  a_reset_quiet: assert property (disable iff (1'b0)
    !i_rstn |=> !o_shared_data_bus_oe && !o_impedance_update) else $error("outputs active in reset");
  a_zq_single: assert property (
    o_impedance_update |=> !o_impedance_update) else $error("update pulse too long");
  a_zq_interval: assert property (
    o_impedance_update && zq_seen_reg |-> zq_cnt_reg == 12'h9c4) else $error("update interval");
  a_read_latency: assert property (
    $rose(o_shared_data_bus_oe) |-> rd_hist_reg[24:14] != 11'h000)
    else $error("bus driven without read load");
  a_idle_float: assert property (
    rd_age_reg > 6'h22 |-> !o_shared_data_bus_oe) else $error("bus driven while idle");
  a_oe_burst: assert property (
    $rose(o_shared_data_bus_oe) |-> o_shared_data_bus_oe [*8]) else $error("burst too short");
  a_echo_source: assert property (
    (!o_single_clock_mode) [*8] ##0 $rose(o_echo_clock_pair_p) |-> $past(i_c, 2) && !$past(i_c, 7))
    else $error("echo rise without output clock rise");
  a_echo_alive: assert property (
    (!o_single_clock_mode) [*8] ##0 $rose(i_c) |-> ##[2:7] $rose(o_echo_clock_pair_p))
    else $error("echo clock missing");
  a_mode_single: assert property (
    (i_c && i_c_n) [*6] |-> o_single_clock_mode) else $error("single clock mode missed");
  a_bypass_follow: assert property (
    $stable(i_pll_bypass_n) [*6] |-> o_pll_bypassed == !i_pll_bypass_n)
    else $error("bypass flag wrong");
  // main scenarios reached
  c_read: cover property ($rose(o_shared_data_bus_oe));
  c_single_read: cover property (o_single_clock_mode && $rose(o_shared_data_bus_oe));
  c_bypass: cover property (o_pll_bypassed);
endmodule

// ==== verif/ddrsp_port_test.sv ====
// self-checking bench for the ddr sram two-word burst port
`timescale 1ns/100ps
module ddrsp_port_test;
  localparam logic [17:0] WA = 18'h1a5a5;
  localparam logic [17:0] WB = 18'h25a5a;
  localparam logic [17:0] WC = 18'h3c3c3;
  localparam logic [17:0] WD = 18'h0f0f0;
  logic core_clk, rstn, run, single, bypass_n, k, k_n, c, c_n, ld_n, rd, start;
  logic oe, echo_p, echo_n, bypassed, single_mode, zq;
  logic [3:0] addr;
  logic [1:0] lane_n;
  logic [17:0] din, dout;
  logic [17:0] exp_q[$];
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  ddrsp_ctrl_model i_ctrl (.i_run(run), .i_single(single), .o_k(k), .o_k_n(k_n), .o_c(c),
    .o_c_n(c_n), .o_load_strobe_n(ld_n), .o_rd_wr_n(rd), .o_addr(addr), .o_start(start),
    .o_lane_n(lane_n), .o_data(din));
  ddrsp_port #(.DATA_W(18), .ADDR_W(4)) i_dut (.i_core_clk(core_clk), .i_rstn(rstn),
    .i_k(k), .i_k_n(k_n), .i_c(c), .i_c_n(c_n), .i_load_strobe_n(ld_n), .i_rd_wr_n(rd),
    .i_addr(addr), .i_burst_start_word_select(start), .i_byte_lane_write_select_n(lane_n),
    .i_shared_data_bus_in(din), .o_shared_data_bus_out(dout), .o_shared_data_bus_oe(oe),
    .o_echo_clock_pair_p(echo_p), .o_echo_clock_pair_n(echo_n), .i_pll_bypass_n(bypass_n),
    .o_pll_bypassed(bypassed), .o_single_clock_mode(single_mode), .o_impedance_update(zq));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input string name, input logic [17:0] e, input logic [17:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", name, e, g);
    end
  endtask
  task automatic rd_go(input logic [3:0] a, input logic s, input logic [17:0] e0,
      input logic [17:0] e1);
    i_ctrl.burst(1'b0, 1'b1, a, s, 18'h00000, 18'h00000, 2'b11, 2'b11);
    exp_q.push_back(e0);
    exp_q.push_back(e1);
  endtask
  // wait for the bus to turn round, then take one word per half input period
  task automatic drain();
    int n;
    n = 0;
    while (oe !== 1'b1 && n < 60) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("oe", 18'h00001, {17'h0, oe});
    for (int i = 0; exp_q.size() > 0; i++) begin
      repeat (i == 0 ? 2 : 5) @(posedge core_clk);
      #1;
      chk("rd_word", exp_q.pop_front(), dout);
    end
    repeat (12) @(posedge core_clk);
    #1;
    chk("oe_idle", 18'h00000, {17'h0, oe});
  endtask
  task automatic t_burst();
    i_ctrl.burst(1'b0, 1'b0, 4'h3, 1'b0, WA, WB, 2'b00, 2'b00);
    rd_go(4'h3, 1'b0, WA, WB);
    rd_go(4'h3, 1'b1, WB, WA);
    drain();
  endtask
  task automatic t_lanes();
    i_ctrl.burst(1'b0, 1'b0, 4'h5, 1'b0, WC, WD, 2'b00, 2'b00);
    i_ctrl.burst(1'b0, 1'b0, 4'h5, 1'b0, 18'h00000, 18'h3ffff, 2'b10, 2'b01);
    rd_go(4'h5, 1'b0, {WC[17:9], 9'h000}, {9'h1ff, WD[8:0]});
    drain();
  endtask
  task automatic t_idle();
    i_ctrl.burst(1'b1, 1'b0, 4'h3, 1'b0, 18'h3ffff, 18'h3ffff, 2'b00, 2'b00);
    rd_go(4'h3, 1'b0, WA, WB);
    drain();
  endtask
  task automatic t_single();
    single = 1'b1;
    repeat (20) @(posedge core_clk);
    #1;
    chk("single_mode", 18'h00001, {17'h0, single_mode});
    rd_go(4'h3, 1'b0, WA, WB);
    drain();
    single = 1'b0;
    repeat (20) @(posedge core_clk);
    #1;
  endtask
  task automatic t_zq();
    int n;
    n = 0;
    while (zq !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (zq !== 1'b1 && n < 3000);
    chk("zq_interval", 18'h009c4, 18'(n));
  endtask
  task automatic t_bypass_stop();
    logic [1:0] e;
    bypass_n = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    chk("bypassed", 18'h00001, {17'h0, bypassed});
    chk("echo_pair", {17'h0, ~echo_p}, {17'h0, echo_n});
    bypass_n = 1'b1;
    run = 1'b0;
    repeat (30) @(posedge core_clk);
    #1;
    e = {echo_n, echo_p};
    // two and a half input periods on: a running echo would show the other phase
    repeat (25) @(posedge core_clk);
    #1;
    chk("echo_stopped", {16'h0, e}, {16'h0, echo_n, echo_p});
    run = 1'b1;
    repeat (30) @(posedge core_clk);
    #1;
    chk("bypass_clear", 18'h00000, {17'h0, bypassed});
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    rstn = 1'b0;
    run = 1'b1;
    single = 1'b0;
    bypass_n = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 rstn = 1'b1;
    repeat (20) @(posedge core_clk);
    t_burst();
    t_lanes();
    t_idle();
    t_single();
    t_bypass_stop();
    t_zq();
    end_sim();
  end
endmodule
bind ddrsp_port ddrsp_port_checker i_chk (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_k(i_k),
  .i_c(i_c), .i_c_n(i_c_n), .i_load_strobe_n(i_load_strobe_n), .i_rd_wr_n(i_rd_wr_n),
  .i_pll_bypass_n(i_pll_bypass_n), .o_shared_data_bus_oe(o_shared_data_bus_oe),
  .o_echo_clock_pair_p(o_echo_clock_pair_p), .o_single_clock_mode(o_single_clock_mode),
  .o_pll_bypassed(o_pll_bypassed), .o_impedance_update(o_impedance_update));
